// ---- bench/sbspc_host.sv ----
`timescale 1ns/10ps
// ****
// shared data wire
// ****
module sbspc_host (
  input wire logic clk_sys,
  input wire sbspc_pkg::sbspc_word_t pin_out,
  input wire logic pin_oe,
  input wire logic host_drv,
  input wire sbspc_pkg::sbspc_word_t host_data,
  output sbspc_pkg::sbspc_word_t pin_in
);
  sbspc_pkg::sbspc_word_t last_reg;
  always_ff @(posedge clk_sys) begin
    last_reg <= pin_in;
  end
  // released lines toggle so a stale value never reads as good data
  assign pin_in = pin_oe ? (host_drv ? 'x : pin_out)
    : (host_drv ? host_data : ~last_reg);
endmodule

// ---- bench/sbspc_sva.sv ----
`timescale 1ns/10ps
// ****
// pin protocol checks
// ****
module sbspc_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire sbspc_pkg::sbspc_ctrl_t ctrl,
  input wire logic out_en_n,
  input wire logic sleep_req,
  input wire logic pin_oe,
  input wire logic asleep
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic sel = !ctrl.chip_sel_a_n && ctrl.chip_sel_b && !ctrl.chip_sel_c_n;
  wire logic go = (!ctrl.proc_addr_strobe_n && !ctrl.chip_sel_a_n) || !ctrl.ctrl_addr_strobe_n;
  wire logic wr = !ctrl.global_write_n && ctrl.proc_addr_strobe_n;
  sequence s_rd;
    !ctrl.proc_addr_strobe_n && sel && !asleep;
  endsequence
  sequence s_both;
    s_rd ##0 (!ctrl.ctrl_addr_strobe_n && !ctrl.global_write_n);
  endsequence
  a_oe_follows_en: assert property (pin_oe |-> !out_en_n)
    else $error("pins driven with enable high");
  a_read_drives: assert property (s_rd |=> pin_oe == !out_en_n)
    else $error("read data not driven");
  a_proc_wins: assert property (s_both |=> pin_oe == !out_en_n)
    else $error("controller strobe acted");
  a_desel_quiet: assert property (go && !sel && !asleep |=> !pin_oe)
    else $error("driven while deselected");
  a_write_release: assert property (wr |=> !pin_oe)
    else $error("pins kept after write");
  a_sleep_quiet: assert property (asleep |-> !pin_oe)
    else $error("driven while asleep");
  // three sync flops, the level flop and the asleep flag, so six edges is a safe bound
  a_sleep_enter: assert property (sleep_req [*6] |-> asleep)
    else $error("sleep not entered");
  a_sleep_exit: assert property (!sleep_req [*6] |-> !asleep)
    else $error("sleep not left");
endmodule
bind sbspc_top sbspc_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .ctrl(ctrl),
  .out_en_n(out_en_n), .sleep_req(sleep_req), .pin_oe(pin_oe), .asleep(asleep));

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic sys_rst = 1'h1, out_en_n = 1'h1, sleep_req = 1'h0, burst_mode = 1'h1, hdrv = 1'h0;
  logic clk_sys, oe_hi = 1'h0, pin_oe, asleep;
  logic [17:0] addr = 18'h0;
  sbspc_pkg::sbspc_ctrl_t ctrl = 10'h3af;
  sbspc_pkg::sbspc_word_t pin_in, pin_out, hdat = 18'h0;
  int errors, compares, cycles;
  sbspc_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr), .ctrl(ctrl),
    .out_en_n(out_en_n), .sleep_req(sleep_req), .burst_mode(burst_mode), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .asleep(asleep));
  sbspc_host u_host (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .host_drv(hdrv),
    .host_data(hdat), .pin_in(pin_in));
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 400) begin
      errors++;
      complete_run;
    end
  end
  task automatic cyc(input logic [9:0] c, input logic [17:0] a, d, input logic w);
    @(negedge clk_sys);
    ctrl = c;
    addr = a;
    hdat = d;
    hdrv = w;
    out_en_n = w | oe_hi;
    @(posedge clk_sys);
    #5;
  endtask
  task automatic chk(input string n, input logic [17:0] e, g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 1'h0;
    cyc(10'h2a7, 18'h4, 18'h2a5c3, 1'h1);
    cyc(10'h1af, 18'h4, 18'h0, 1'h0);
    chk("rd", 18'h2a5c3, pin_out);
    chk("oe", 18'h1, 18'(pin_oe));
    cyc(10'h2aa, 18'h4, 18'h1ff00, 1'h1);
    cyc(10'h1af, 18'h4, 18'h0, 1'h0);
    chk("lane", 18'h3a500, pin_out);
    cyc(10'h1ef, 18'h8, 18'h0, 1'h0);
    chk("gate", 18'h3a500, pin_out);
    cyc(10'h0a7, 18'h4, 18'h1, 1'h1);
    cyc(10'h1af, 18'h4, 18'h0, 1'h0);
    chk("both", 18'h3a500, pin_out);
    $display("test select done");
    for (int i = 0; i < 4; i++) cyc(10'h2a7, 18'(16 + i), 18'(256 + i), 1'h1);
    // interleaved xors the step into the seed, linear adds it
    for (int m = 1; m >= 0; m--) begin
      @(negedge clk_sys) burst_mode = m[0];
      repeat (5) cyc(10'h3af, 18'h0, 18'h0, 1'h0);
      cyc(10'h1af, 18'h11, 18'h0, 1'h0);
      for (int i = 0; i < 5; i++) begin
        if (i > 0) cyc(10'h32f, 18'h0, 18'h0, 1'h0);
        chk("burst", 18'(m ? 256 + (1 ^ (i & 3)) : 256 + ((1 + i) & 3)), pin_out);
      end
    end
    $display("test burst done");
    cyc(10'h28f, 18'h4, 18'h0, 1'h0);
    chk("desel", 18'h0, 18'(pin_oe));
    oe_hi = 1'h1;
    cyc(10'h1af, 18'h4, 18'h0, 1'h0);
    chk("oe_off", 18'h0, 18'(pin_oe));
    oe_hi = 1'h0;
    cyc(10'h1af, 18'h20, 18'h0, 1'h0);
    cyc(10'h3a7, 18'h20, 18'h15555, 1'h1);
    cyc(10'h1af, 18'h20, 18'h0, 1'h0);
    chk("pwr", 18'h15555, pin_out);
    $display("test pins done");
    cyc(10'h28f, 18'h4, 18'h0, 1'h0);
    @(negedge clk_sys) sleep_req = 1'h1;
    repeat (8) cyc(10'h3af, 18'h0, 18'h0, 1'h0);
    chk("asleep", 18'h1, 18'(asleep));
    cyc(10'h2a7, 18'h4, 18'h0, 1'h1);
    @(negedge clk_sys) sleep_req = 1'h0;
    repeat (8) cyc(10'h3af, 18'h0, 18'h0, 1'h0);
    cyc(10'h1af, 18'h4, 18'h0, 1'h0);
    chk("keep", 18'h3a500, pin_out);
    $display("test sleep done");
    complete_run;
  end
endmodule

// ---- verilog/sbspc_pkg.sv ----
package sbspc_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int ADDR_W = 18;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int LANES = 2;
  localparam int LANE_DATA_W = 8;
  localparam int LANE_W = LANE_DATA_W + 1;
  localparam int DATA_W = LANES * LANE_DATA_W;
  localparam int BURST_W = 2;

  // ************************************************************
  // pin conditioning and reset values
  // ************************************************************
  localparam int SYNC_STAGES = 3;
  localparam int SYNC_PINS = 2;
  localparam int SYNC_SLEEP = 0;
  localparam int SYNC_MODE = 1;
  // sleep idles inactive, burst order idles interleaved (high)
  localparam logic [SYNC_PINS-1:0] SYNC_RST = 2'h2;
  localparam logic [BURST_W-1:0] STEP_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [LANES-1:0] parity_io;
    logic [DATA_W-1:0] data;
  } sbspc_word_t;

  typedef struct packed {
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic chip_sel_a_n;
    logic chip_sel_b;
    logic chip_sel_c_n;
    logic global_write_n;
    logic byte_write_en_n;
    logic [LANES-1:0] byte_lane_sel_n;
  } sbspc_ctrl_t;

endpackage

// ---- verilog/sbspc_top.sv ----
`timescale 1ns/10ps

module sbspc_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [sbspc_pkg::ADDR_W-1:0] addr,
  input wire sbspc_pkg::sbspc_ctrl_t ctrl,
  input wire logic out_en_n,
  input wire logic sleep_req,
  input wire logic burst_mode,
  input wire sbspc_pkg::sbspc_word_t pin_in,
  output sbspc_pkg::sbspc_word_t pin_out,
  output logic pin_oe,
  output logic asleep
);

  // ************************************************************
  // asynchronous pin conditioning
  // ************************************************************
  // sleep and burst order come from outside the clock; a level change is
  // accepted only once the last two stages agree, which filters glitches
  logic [sbspc_pkg::SYNC_PINS-1:0] pin_raw;
  logic [sbspc_pkg::SYNC_PINS-1:0] pin_level;

  assign pin_raw[sbspc_pkg::SYNC_SLEEP] = sleep_req;
  assign pin_raw[sbspc_pkg::SYNC_MODE] = burst_mode;

  genvar gp;
  generate
    for (gp = 0; gp < sbspc_pkg::SYNC_PINS; gp++) begin : g_sync
      logic [sbspc_pkg::SYNC_STAGES-1:0] stage_reg;
      logic level_reg;
      wire agree = (stage_reg[1] == stage_reg[2]);
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          stage_reg <= {sbspc_pkg::SYNC_STAGES{sbspc_pkg::SYNC_RST[gp]}};
          level_reg <= sbspc_pkg::SYNC_RST[gp];
        end else begin
          stage_reg <= {stage_reg[1:0], pin_raw[gp]};
          if (agree) begin
            level_reg <= stage_reg[2];
          end
        end
      end
      assign pin_level[gp] = level_reg;
    end
  endgenerate

  wire sleeping = pin_level[sbspc_pkg::SYNC_SLEEP];
  wire interleave = pin_level[sbspc_pkg::SYNC_MODE];

  // ************************************************************
  // strobe and select decode
  // ************************************************************
  wire selected = ~ctrl.chip_sel_a_n & ctrl.chip_sel_b & ~ctrl.chip_sel_c_n;
  wire proc_start = ~ctrl.proc_addr_strobe_n & ~ctrl.chip_sel_a_n;
  wire ctrl_start = ~ctrl.ctrl_addr_strobe_n & ~proc_start;
  wire start = ~sleeping & (proc_start | ctrl_start);

  // ************************************************************
  // write decode
  // ************************************************************
  logic [sbspc_pkg::LANES-1:0] lane_wr;
  assign lane_wr = ~ctrl.global_write_n ? {sbspc_pkg::LANES{1'b1}} :
                   ~ctrl.byte_write_en_n ? ~ctrl.byte_lane_sel_n :
                   {sbspc_pkg::LANES{1'b0}};

  // ************************************************************
  // access state
  // ************************************************************
  logic active_reg;
  logic active_next;
  logic [sbspc_pkg::ADDR_W-1:0] addr_reg;
  logic [sbspc_pkg::ADDR_W-1:0] addr_next;
  logic [sbspc_pkg::BURST_W-1:0] step_reg;
  logic [sbspc_pkg::BURST_W-1:0] step_next;
  logic write_hiz_reg;
  logic write_hiz_next;
  logic asleep_reg;

  // a start while deselected ends any burst in flight
  assign active_next = sleeping ? 1'b0 : start ? selected : active_reg;
  assign addr_next = start ? addr : addr_reg;
  // the step counter is two bits wide, so it wraps by construction
  assign step_next = start ? sbspc_pkg::STEP_RST :
                     (~ctrl.burst_advance_n ? step_reg + 2'h1 : step_reg);

  // the seed bits are combined with the step in the chosen order
  wire [sbspc_pkg::BURST_W-1:0] seed = addr_next[sbspc_pkg::BURST_W-1:0];
  wire [sbspc_pkg::BURST_W-1:0] low_bits = interleave ? (seed ^ step_next) :
                                                        (seed + step_next);
  wire [sbspc_pkg::ADDR_W-1:0] access_addr =
    {addr_next[sbspc_pkg::ADDR_W-1:sbspc_pkg::BURST_W], low_bits};

  // a processor-started access ignores the write pins on its first edge
  wire write_ok = active_next & ~(start & proc_start);
  wire [sbspc_pkg::LANES-1:0] lane_we = write_ok ? lane_wr : {sbspc_pkg::LANES{1'b0}};
  wire write_now = |lane_we;
  assign write_hiz_next = write_now;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      active_reg <= 1'b0;
      addr_reg <= sbspc_pkg::ADDR_RST;
      step_reg <= sbspc_pkg::STEP_RST;
      write_hiz_reg <= 1'b0;
      asleep_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      asleep_reg <= sleeping;
      write_hiz_reg <= write_hiz_next;
      if (~sleeping) begin
        addr_reg <= addr_next;
        step_reg <= step_next;
      end
    end
  end

  // ************************************************************
  // storage, one array per byte lane with its parity bit
  // ************************************************************
  logic [sbspc_pkg::LANES*sbspc_pkg::LANE_W-1:0] rd_word;

  genvar gl;
  generate
    for (gl = 0; gl < sbspc_pkg::LANES; gl++) begin : g_lane
      logic [sbspc_pkg::LANE_W-1:0] mem [0:sbspc_pkg::DEPTH-1];
      logic [sbspc_pkg::LANE_W-1:0] rd_reg;
      // parity bit n rides with byte n through the whole path
      wire [sbspc_pkg::LANE_W-1:0] wr_lane = {pin_in.parity_io[gl],
        pin_in.data[gl*sbspc_pkg::LANE_DATA_W +: sbspc_pkg::LANE_DATA_W]};
      // the array is not reset: its contents survive reset and sleep
      always_ff @(posedge clk_sys) begin
        if (lane_we[gl]) begin
          mem[access_addr] <= wr_lane;
        end
        if (active_next & ~write_now) begin
          rd_reg <= mem[access_addr];
        end
      end
      assign rd_word[gl*sbspc_pkg::LANE_W +: sbspc_pkg::LANE_W] = rd_reg;
    end
  endgenerate

  // ************************************************************
  // pin drivers
  // ************************************************************
  genvar gb;
  generate
    for (gb = 0; gb < sbspc_pkg::LANES; gb++) begin : g_out
      assign pin_out.parity_io[gb] = rd_word[gb*sbspc_pkg::LANE_W + sbspc_pkg::LANE_DATA_W];
      assign pin_out.data[gb*sbspc_pkg::LANE_DATA_W +: sbspc_pkg::LANE_DATA_W] =
        rd_word[gb*sbspc_pkg::LANE_W +: sbspc_pkg::LANE_DATA_W];
    end
  endgenerate

  // output enable must act without the clock, so the enable is gated
  // combinationally from the pin and the registered cycle state
  assign pin_oe = ~out_en_n & active_reg & ~write_hiz_reg & ~sleeping;
  assign asleep = asleep_reg;

endmodule
